// file: dv/core_model.sv
// core model that executes the sleep instruction on request
`timescale 1ns/1ns
module core_model (
    // clock
    input wire i_clk,
    // request from the bench
    input wire i_req,
    input wire i_deep,
    // to the controller
    output reg o_sleep_instruction,
    output reg o_deep_sleep_bit
);
    initial begin
        o_sleep_instruction = 1'b0;
        o_deep_sleep_bit = 1'b0;
    end
    // the deep bit travels with the strobe so the choice is fixed at execution
    always @(posedge i_clk) begin
        o_sleep_instruction <= i_req;
        o_deep_sleep_bit <= i_deep;
    end
endmodule // core_model

// file: dv/stop_ctrl_assertions.sv
// concurrent checks on the ports of the stop-mode controller
`timescale 1ns/1ns
module stop_ctrl_assertions (
    // clock and reset
    input logic i_clk,
    input logic i_reset,
    // write response
    input logic i_bready,
    input logic o_bvalid,
    input logic [1:0] o_bresp,
    // core side
    input logic i_sleep_instruction,
    input logic i_deep_sleep_bit,
    input logic o_core_wait,
    input logic o_core_stop,
    input logic o_wake_irq,
    input logic o_wake_reset,
    // power domain controls
    input logic o_volt_detect_en,
    input logic o_regfile_pwr,
    input logic o_radio_retain,
    input logic o_radio_pwr,
    input logic [1:0] o_sram_pwr,
    input logic o_analog_en,
    input logic o_osc_en,
    input logic o_periph_wake_en,
    input logic o_pad_retention_state
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    ////////////////////////////////////////////////////////////////////////////////
    // the pulse is ten cycles; unrolled in two short repetitions
    sequence s_rst_hold;
        o_wake_reset[*8] ##1 o_wake_reset[*2];
    endsequence
    property p_rst_len;
        $rose(o_wake_reset) |-> s_rst_hold ##1 !o_wake_reset;
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("wake reset length wrong");
    property p_detect_stop;
        $rose(o_core_stop) |=> !o_volt_detect_en;
    endproperty
    a_detect_stop: assert property (p_detect_stop) else $error("voltage detect on in stop");
    property p_irq_pulse;
        o_wake_irq |=> !o_wake_irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("wake irq too long");
    property p_regfile;
        o_regfile_pwr;
    endproperty
    a_regfile: assert property (p_regfile) else $error("register file unpowered");
    property p_lvl0_gate;
        o_pad_retention_state |-> !(o_radio_pwr | o_analog_en | o_osc_en | o_periph_wake_en);
    endproperty
    a_lvl0_gate: assert property (p_lvl0_gate) else $error("level0 domain left on");
    property p_radio_retain;
        o_radio_retain |-> o_radio_pwr && (o_sram_pwr != 2'h0);
    endproperty
    a_radio_retain: assert property (p_radio_retain) else $error("retain while gated");
    property p_sram_off;
        !o_radio_pwr |-> (o_sram_pwr == 2'h0) && o_regfile_pwr;
    endproperty
    a_sram_off: assert property (p_sram_off) else $error("sram kept in level1/0");
    property p_wait_entry;
        i_sleep_instruction && !i_deep_sleep_bit && !o_core_wait && !o_core_stop && !o_wake_reset
            |=> o_core_wait && !o_core_stop;
    endproperty
    a_wait_entry: assert property (p_wait_entry) else $error("wait not entered");
    property p_b_hold;
        o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
endmodule // stop_ctrl_assertions
bind low_power_stop_mode_control stop_ctrl_assertions u_chk (.*);

// file: dv/tb_top.sv
// self-checking bench for the stop-mode controller
`timescale 1ns/1ns
`include "stop_ctrl_regs.vh"
module tb_top;
    reg i_clk = 1'b0;
    reg i_reset = 1'b1;
    reg [7:0] i_awaddr = 8'h00;
    reg [7:0] i_araddr = 8'h00;
    reg [31:0] i_wdata = 32'h0000_0000;
    reg [3:0] i_wstrb = 4'hf;
    reg i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
    reg req = 1'b0, deep = 1'b0, i_pin_wake = 1'b0, i_periph_wake = 1'b0, irq, done;
    wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_core_wait, o_core_stop;
    wire o_wake_irq, o_wake_reset, o_volt_detect_en, o_bias_en, o_logic_retain, o_regfile_pwr;
    wire o_radio_retain, o_radio_pwr, o_analog_en, o_osc_en, o_bod_en, o_pad_retention_state;
    wire o_periph_wake_en, i_sleep_instruction, i_deep_sleep_bit;
    wire [1:0] o_bresp, o_rresp, o_sram_pwr;
    wire [31:0] o_rdata;
    wire [12:0] pw = {o_volt_detect_en, o_bias_en, o_logic_retain, o_sram_pwr, o_regfile_pwr,
        o_radio_retain, o_radio_pwr, o_analog_en, o_osc_en, o_bod_en, o_pad_retention_state,
        o_periph_wake_en};
    integer error_cnt = 0, checks = 0, i, n;
    reg [7:0] len;
    reg [23:0] e;
    // entry: expected power vector above, ctrl value in the low byte
    localparam [215:0] TBL = {24'h08_8616, 24'h08_8206, 24'h08_9d05, 24'h09_fd04,
        24'h0b_fd03, 24'h0e_fd22, 24'h0f_fd01, 24'h0b_bd00, 24'h03_bd40};
    low_power_stop_mode_control DUT (.*);
    core_model u_core (.i_clk(i_clk), .i_req(req), .i_deep(deep),
        .o_sleep_instruction(i_sleep_instruction), .o_deep_sleep_bit(i_deep_sleep_bit));
    ////////////////////////////////////////////////////////////////////////////////
    task stop_test;
        begin
            $display("errors %0d checks %0d", error_cnt, checks);
            if (error_cnt == 0 && checks > 0) begin
                $display("verification passed");
            end else begin
                $display("verification failed");
            end
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[ERR] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task tick;
        begin
            @(posedge i_clk);
            n = n + 1;
            if (n > 60) begin
                error_cnt = error_cnt + 1;
                $display("[ERR] %0t wait timed out", $time);
                stop_test;
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        begin
            @(posedge i_clk);
            {i_awaddr, i_wdata} <= {a, d};
            {i_awvalid, i_wvalid, i_bready} <= 3'h7;
            {done, n} = 0;
            while (!done) begin
                tick;
                if (i_awvalid && o_awready) i_awvalid <= 1'b0;
                if (i_wvalid && o_wready) i_wvalid <= 1'b0;
                if (o_bvalid) begin
                    i_bready <= 1'b0;
                    done = 1'b1;
                    chk(o_bresp, er);
                end
            end
        end
    endtask
    task rd(input [7:0] a, input [31:0] exp, input [31:0] m, input [1:0] er);
        begin
            @(posedge i_clk);
            i_araddr <= a;
            {i_arvalid, i_rready} <= 2'h3;
            {done, n} = 0;
            while (!done) begin
                tick;
                if (i_arvalid && o_arready) i_arvalid <= 1'b0;
                if (o_rvalid) begin
                    i_rready <= 1'b0;
                    done = 1'b1;
                    chk(o_rdata & m, exp);
                    chk(o_rresp, er);
                end
            end
        end
    endtask
    // strobe reaches the controller one cycle after req, outputs settle two later
    task sleep_req(input d);
        begin
            @(posedge i_clk);
            {req, deep} <= {1'b1, d};
            @(posedge i_clk);
            req <= 1'b0;
            repeat (5) @(posedge i_clk);
        end
    endtask
    task wake_up;
        begin
            @(posedge i_clk);
            i_pin_wake <= 1'b1;
            n = 0;
            while (!(o_wake_irq || o_wake_reset)) tick;
            irq = o_wake_irq;
            {i_pin_wake, i_periph_wake} <= 2'h0;
            len = 0;
            while (o_wake_reset) begin
                len = len + 1;
                tick;
            end
            repeat (2) @(posedge i_clk);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial forever #5 i_clk = ~i_clk;
    initial begin
        repeat (3) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        chk(pw, 13'h1_bbd);
        rd(8'h10, 32'h0000_0000, 32'hffff_ffff, 2'h2);
        wr(8'h10, 32'h0000_0000, 2'h2);
        wr(`SC_FILE_OFS, 32'ha5a5_5a5a, 2'h0);
        for (i = 0; i < 9; i = i + 1) begin
            e = TBL[i*24 +: 24];
            wr(`SC_CTRL_OFS, {24'h00_0000, e[7:0]}, 2'h0);
            sleep_req(1'b1);
            chk(o_core_stop, 1'b1);
            chk(pw, e[20:8]);
            if (e[2:0] == `SC_MODE_VLL0) begin
                @(posedge i_clk) i_periph_wake <= 1'b1;
                repeat (8) @(posedge i_clk);
                chk(o_core_stop, 1'b1);
            end
            wake_up;
            chk(irq, e[2:0] < `SC_MODE_VLL3);
            chk(len, irq ? 0 : `SC_WAKE_RST_CYC);
            rd(`SC_STAT_OFS, irq ? 32'h0000_0000 : 32'h0000_0010, 32'h0000_0037, 2'h0);
            wr(`SC_STAT_OFS, 32'h0000_0000, 2'h0);
        end
        rd(`SC_FILE_OFS, 32'ha5a5_5a5a, 32'hffff_ffff, 2'h0);
        // level0 refused in buck and in boost; the unused mode code 7 refused as well
        for (i = 1; i < 4; i = i + 1) begin
            wr(`SC_CFG_OFS, (i < 3) ? i : 0, 2'h0);
            wr(`SC_CTRL_OFS, (i < 3) ? {29'h0, `SC_MODE_VLL0} : 32'h0000_0007, 2'h0);
            sleep_req(1'b1);
            chk(o_core_stop, 1'b0);
            rd(`SC_STAT_OFS, 32'h0000_0020, 32'h0000_0037, 2'h0);
            wr(`SC_STAT_OFS, 32'h0000_0000, 2'h0);
        end
        wr(`SC_CFG_OFS, 32'h0000_0000, 2'h0);
        sleep_req(1'b0);
        chk({o_core_wait, o_core_stop}, 2'h2);
        wake_up;
        chk(irq, 1'b1);
        stop_test;
    end
endmodule // tb_top

// file: hw/low_power_stop_mode_control.v
// low-power stop-mode controller with axi4-lite register slave
//
// Functional notes
// - very-low-power stop: static core, detect off, pins alive
// - continuous converter: bias off in very-low-power stop
// - low-leak stops retain logic, wakeup interrupt
// - level2 low-leak keeps 16 or 32 KB
// - vll level3: full sram, wakeup reset
// - vll level2: 16/32 KB sram, wakeup reset
// - vll level1: sram off, register file kept
// - vll levels 1,0 power-gate radio logic
// - level0: analog, oscillator off, pins wake
// - level0 with or without brown-out detection
`timescale 1ns/1ns
`include "stop_ctrl_regs.vh"
module low_power_stop_mode_control (
    // clock and reset
    input wire i_clk,
    input wire i_reset,
    // axi4-lite write address
    input wire [7:0] i_awaddr,
    input wire i_awvalid,
    output reg o_awready,
    // axi4-lite write data
    input wire [31:0] i_wdata,
    input wire [3:0] i_wstrb,
    input wire i_wvalid,
    output reg o_wready,
    // axi4-lite write response
    output reg [1:0] o_bresp,
    output reg o_bvalid,
    input wire i_bready,
    // axi4-lite read address
    input wire [7:0] i_araddr,
    input wire i_arvalid,
    output reg o_arready,
    // axi4-lite read data
    output reg [31:0] o_rdata,
    output reg [1:0] o_rresp,
    output reg o_rvalid,
    input wire i_rready,
    // core side
    input wire i_sleep_instruction,
    input wire i_deep_sleep_bit,
    output reg o_core_wait,
    output reg o_core_stop,
    output reg o_wake_irq,
    output reg o_wake_reset,
    // wake sources from pins and peripherals (asynchronous)
    input wire i_pin_wake,
    input wire i_periph_wake,
    // power domain controls
    output reg o_volt_detect_en,
    output reg o_bias_en,
    output reg o_logic_retain,
    output reg [1:0] o_sram_pwr,
    output reg o_regfile_pwr,
    output reg o_radio_retain,
    output reg o_radio_pwr,
    output reg o_analog_en,
    output reg o_osc_en,
    output reg o_bod_en,
    output reg o_pad_retention_state,
    output reg o_periph_wake_en
);
    localparam ST_RUN = 3'h0;
    localparam ST_WAIT = 3'h1;
    localparam ST_STOP = 3'h2;
    localparam ST_WAKE_RST = 3'h3;
    // sram power codes: off, 16 KB, 32 KB, all
    localparam SRAM_OFF = 2'h0;
    localparam SRAM_16K = 2'h1;
    localparam SRAM_32K = 2'h2;
    localparam SRAM_ALL = 2'h3;
    ////////////////////////////////////////////////////////////////////////////////
    // synchronisers
    reg [1:0] pin_sync_q;
    reg [1:0] per_sync_q;
    // no reset: the sequencer ignores wakes while in reset, so flush is enough
    always @(posedge i_clk) begin
        pin_sync_q <= {pin_sync_q[0], i_pin_wake};
        per_sync_q <= {per_sync_q[0], i_periph_wake};
    end
    wire pin_wake = pin_sync_q[1];
    wire per_wake = per_sync_q[1];
    ////////////////////////////////////////////////////////////////////////////////
    // registers
    reg [31:0] ctrl_q;
    reg [31:0] cfg_q;
    reg [2:0] state_q;
    reg [2:0] mode_q;
    reg wakerst_flag_q;
    reg refused_q;
    reg [7:0] rst_cnt_q;
    wire [2:0] ctrl_mode = ctrl_q[`SC_CTRL_MODE_LSB +: `SC_CTRL_MODE_W];
    wire [1:0] conv = cfg_q[`SC_CFG_CONV_LSB +: `SC_CFG_CONV_W];
    // axi write side
    reg aw_hold_q;
    reg w_hold_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    wire aw_take = i_awvalid && o_awready;
    wire w_take = i_wvalid && o_wready;
    wire aw_have = aw_hold_q || aw_take;
    wire w_have = w_hold_q || w_take;
    wire [7:0] wa = aw_hold_q ? awaddr_q : i_awaddr;
    wire [31:0] wd = w_hold_q ? wdata_q : i_wdata;
    wire [3:0] ws = w_hold_q ? wstrb_q : i_wstrb;
    wire wr_fire = aw_have && w_have && !o_bvalid;
    wire wr_ctrl = wr_fire && (wa == `SC_CTRL_OFS);
    wire wr_cfg = wr_fire && (wa == `SC_CFG_OFS);
    wire wr_file = wr_fire && (wa[7:5] == 3'h1) && (wa[1:0] == 2'h0);
    wire wr_ok = wr_ctrl || wr_cfg || wr_file || (wa == `SC_STAT_OFS);
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp <= 2'h0;
        end else begin
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                o_awready <= 1'b0;
                o_wready <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= wr_ok ? 2'h0 : 2'h2;
            end else begin
                if (aw_take) begin
                    awaddr_q <= i_awaddr;
                    aw_hold_q <= 1'b1;
                    o_awready <= 1'b0;
                end
                if (w_take) begin
                    wdata_q <= i_wdata;
                    wstrb_q <= i_wstrb;
                    w_hold_q <= 1'b1;
                    o_wready <= 1'b0;
                end
            end
            if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
                o_awready <= 1'b1;
                o_wready <= 1'b1;
            end
        end
    end
    // retained file survives i_reset and wakeup reset alike
    wire [31:0] file_rdata;
    retained_file u_file (
        .i_clk(i_clk),
        .i_we(wr_file),
        .i_waddr(wa[4:2]),
        .i_wdata(wd),
        .i_wstrb(ws),
        .i_raddr(i_araddr[4:2]),
        .o_rdata(file_rdata)
    );
    // axi read side: one cycle to fetch, answer the next
    reg rd_pend_q;
    reg [7:0] raddr_q;
    wire ar_take = i_arvalid && o_arready;
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_arready <= 1'b1;
            rd_pend_q <= 1'b0;
            raddr_q <= 8'h00;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= 2'h0;
        end else begin
            rd_pend_q <= ar_take;
            if (ar_take) begin
                raddr_q <= i_araddr;
                o_arready <= 1'b0;
            end
            if (rd_pend_q) begin
                o_rvalid <= 1'b1;
                o_rresp <= 2'h0;
                if (raddr_q == `SC_CTRL_OFS) begin
                    o_rdata <= ctrl_q;
                end else if (raddr_q == `SC_STAT_OFS) begin
                    o_rdata <= {26'h0, refused_q, wakerst_flag_q, 1'b0, state_q};
                end else if (raddr_q == `SC_CFG_OFS) begin
                    o_rdata <= cfg_q;
                end else if (raddr_q[7:5] == 3'h1 && raddr_q[1:0] == 2'h0) begin
                    o_rdata <= file_rdata;
                end else begin
                    o_rdata <= 32'h0000_0000;
                    o_rresp <= 2'h2;
                end
            end
            if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
                o_arready <= 1'b1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // mode sequencer
    wire is_lls = (mode_q == `SC_MODE_LL_STOP3) || (mode_q == `SC_MODE_LL_STOP2);
    wire is_vll = (mode_q == `SC_MODE_VLL3) || (mode_q == `SC_MODE_VLL2) ||
                  (mode_q == `SC_MODE_VLL1) || (mode_q == `SC_MODE_VLL0);
    // level0 accepts only pin wake; others accept peripheral wake too
    wire wake_ev = pin_wake || (per_wake && (mode_q != `SC_MODE_VLL0));
    wire bad_vll0 = (ctrl_mode == `SC_MODE_VLL0) && (conv != `SC_CONV_BYPASS);
    wire bad_mode = ctrl_mode > `SC_MODE_VLL0;
    always @(posedge i_clk) begin
        if (i_reset) begin
            ctrl_q <= `SC_CTRL_RESET;
            cfg_q <= `SC_CFG_RESET;
            state_q <= ST_RUN;
            mode_q <= `SC_MODE_VLP_STOP;
            wakerst_flag_q <= 1'b0;
            refused_q <= 1'b0;
            rst_cnt_q <= 8'h00;
            o_core_wait <= 1'b0;
            o_core_stop <= 1'b0;
            o_wake_irq <= 1'b0;
            o_wake_reset <= 1'b0;
        end else begin
            o_wake_irq <= 1'b0;
            if (wr_ctrl && ws[0]) begin
                ctrl_q <= {25'h000_0000, wd[6:0]};
            end
            if (wr_cfg && ws[0]) begin
                cfg_q <= {30'h0000_0000, wd[`SC_CFG_CONV_LSB +: `SC_CFG_CONV_W]};
            end
            // writing status clears its flags
            if (wr_fire && wa == `SC_STAT_OFS) begin
                wakerst_flag_q <= 1'b0;
                refused_q <= 1'b0;
            end
            case (state_q)
                ST_RUN: begin
                    if (i_sleep_instruction && !i_deep_sleep_bit) begin
                        state_q <= ST_WAIT;
                        o_core_wait <= 1'b1;
                    end else if (i_sleep_instruction) begin
                        if (bad_vll0 || bad_mode) begin
                            refused_q <= 1'b1;
                        end else begin
                            state_q <= ST_STOP;
                            mode_q <= ctrl_mode;
                            o_core_stop <= 1'b1;
                        end
                    end
                end
                ST_WAIT: begin
                    if (wake_ev || per_wake) begin
                        state_q <= ST_RUN;
                        o_core_wait <= 1'b0;
                        o_wake_irq <= 1'b1;
                    end
                end
                ST_STOP: begin
                    if (wake_ev) begin
                        o_core_stop <= 1'b0;
                        if (is_vll) begin
                            state_q <= ST_WAKE_RST;
                            o_wake_reset <= 1'b1;
                            rst_cnt_q <= 8'h00;
                        end else begin
                            state_q <= ST_RUN;
                            o_wake_irq <= 1'b1;
                        end
                    end
                end
                ST_WAKE_RST: begin
                    rst_cnt_q <= rst_cnt_q + 8'h01;
                    if (rst_cnt_q == `SC_WAKE_RST_CYC - 1) begin
                        state_q <= ST_RUN;
                        o_wake_reset <= 1'b0;
                        wakerst_flag_q <= 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // power domain outputs, registered from state, captured mode and the live ctrl bits
    wire stop = (state_q == ST_STOP);
    wire m_vlp = stop && (mode_q == `SC_MODE_VLP_STOP);
    wire m_ll2 = stop && (mode_q == `SC_MODE_LL_STOP2);
    wire m_v2 = stop && (mode_q == `SC_MODE_VLL2);
    wire m_v1 = stop && (mode_q == `SC_MODE_VLL1);
    wire m_v0 = stop && (mode_q == `SC_MODE_VLL0);
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_volt_detect_en <= 1'b1;
            o_bias_en <= 1'b1;
            o_logic_retain <= 1'b0;
            o_sram_pwr <= SRAM_ALL;
            o_regfile_pwr <= 1'b1;
            o_radio_retain <= 1'b0;
            o_radio_pwr <= 1'b1;
            o_analog_en <= 1'b1;
            o_osc_en <= 1'b1;
            o_bod_en <= 1'b1;
            o_pad_retention_state <= 1'b0;
            o_periph_wake_en <= 1'b1;
        end else begin
            o_volt_detect_en <= !stop;
            o_bias_en <= !(m_vlp && ctrl_q[`SC_CTRL_CONT_BIT]);
            o_logic_retain <= stop && is_lls;
            if (m_ll2 || m_v2) begin
                o_sram_pwr <= ctrl_q[`SC_CTRL_RAM32_BIT] ? SRAM_32K : SRAM_16K;
            end else if (m_v1 || m_v0) begin
                o_sram_pwr <= SRAM_OFF;
            end else begin
                o_sram_pwr <= SRAM_ALL;
            end
            o_regfile_pwr <= 1'b1;
            o_radio_retain <= stop && (is_lls || m_v2 || (mode_q == `SC_MODE_VLL3));
            o_radio_pwr <= !(m_v1 || m_v0);
            o_analog_en <= !m_v0;
            o_osc_en <= !m_v0;
            o_bod_en <= !(m_v0 && !ctrl_q[`SC_CTRL_BOD_BIT]);
            o_pad_retention_state <= m_v0;
            o_periph_wake_en <= !m_v0;
        end
    end
endmodule // low_power_stop_mode_control

// file: hw/retained_file.v
// retained 32-byte application register file, kept across wakeup reset
`timescale 1ns/1ns
module retained_file (
    // clock
    input wire i_clk,
    // access
    input wire i_we,
    input wire [2:0] i_waddr,
    input wire [31:0] i_wdata,
    input wire [3:0] i_wstrb,
    input wire [2:0] i_raddr,
    output reg [31:0] o_rdata
);
    reg [31:0] mem [0:7];
    genvar g;
    // no reset: contents must survive both system and wakeup reset
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_lane
            always @(posedge i_clk) begin
                if (i_we && i_wstrb[g]) begin
                    mem[i_waddr][8*g+7:8*g] <= i_wdata[8*g+7:8*g];
                end
            end
        end
    endgenerate
    always @(posedge i_clk) begin
        o_rdata <= mem[i_raddr];
    end
endmodule // retained_file

// file: hw/stop_ctrl_regs.vh
// register offsets, field positions, reset values and timing counts of the stop-mode controller
`ifndef STOP_CTRL_REGS_VH
`define STOP_CTRL_REGS_VH
// register byte offsets
`define SC_CTRL_OFS 8'h00
`define SC_STAT_OFS 8'h04
`define SC_CFG_OFS 8'h08
`define SC_FILE_OFS 8'h20
// ctrl fields
`define SC_CTRL_MODE_LSB 0
`define SC_CTRL_MODE_W 3
`define SC_CTRL_BOD_BIT 4
`define SC_CTRL_RAM32_BIT 5
`define SC_CTRL_CONT_BIT 6
// cfg fields: converter configuration
`define SC_CFG_CONV_LSB 0
`define SC_CFG_CONV_W 2
`define SC_CONV_BYPASS 2'h0
`define SC_CONV_BUCK 2'h1
`define SC_CONV_BOOST 2'h2
// stop mode encodings
`define SC_MODE_VLP_STOP 3'h0
`define SC_MODE_LL_STOP3 3'h1
`define SC_MODE_LL_STOP2 3'h2
`define SC_MODE_VLL3 3'h3
`define SC_MODE_VLL2 3'h4
`define SC_MODE_VLL1 3'h5
`define SC_MODE_VLL0 3'h6
// status fields
`define SC_STAT_STATE_LSB 0
`define SC_STAT_WAKERST_BIT 4
`define SC_STAT_REFUSED_BIT 5
// reset values
`define SC_CTRL_RESET 32'h0000_0000
`define SC_CFG_RESET 32'h0000_0000
// register file of 32 bytes as 8 words
`define SC_FILE_WORDS 8
// wakeup reset pulse length
`define SC_WAKE_RST_NS 100
`define SC_WAKE_RST_CYC ((`SC_WAKE_RST_NS + 9) / 10)
`endif
